// *** smc_pkg.sv ***
// Purpose: constants for the SPI master clock and status block
// Assumes: byte-address register port, 32-bit data
// Notes: offsets are byte addresses
`default_nettype none
package smc_pkg;
  localparam logic [31:0] CFG_ADDR  = 32'h4000_1820;
  localparam logic [31:0] DATA_ADDR = 32'h4000_1824;
  localparam logic [31:0] CLK_ADDR  = 32'h4000_1828;
  localparam logic [31:0] STAT_ADDR = 32'h4000_182C;
  localparam int CFG_SPOS  = 5;
  localparam int CFG_SEL   = 6;
  localparam int CFG_EN    = 7;
  localparam logic [7:0] CFG_RST  = 8'h40;
  localparam logic [7:0] CFG_WMSK = 8'hEF;
  localparam int CLK_CPOL  = 0;
  localparam int CLK_CPHA  = 1;
  localparam int CLK_DIVLO = 2;
  localparam logic [7:0] CLK_RST  = 8'h07;
  localparam int ST_OVF   = 0;
  localparam int ST_RXF   = 1;
  localparam int ST_TXE   = 2;
  localparam int ST_WCOL  = 3;
  localparam int ST_BUSY  = 4;
  localparam int ST_FLUSH = 7;
  localparam logic ST_TXE_RST = 1'b1;
  localparam logic SCK_RST    = 1'b1;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  typedef enum logic {SMC_IDLE, SMC_SHIFT} smc_state_t;
endpackage
`default_nettype wire

// *** smc_link_if.sv ***
// Purpose: link between register side and shift engine
// Assumes: single clock domain
// Notes: edge_stb comes from the clock generator
`timescale 1ns/1ns
`default_nettype none
interface smc_link_if;
  logic       start;
  logic [7:0] tx_byte;
  logic       cpol;
  logic       cpha;
  logic       spos;
  logic       en;
  logic       miso;
  logic       edge_stb;
  logic       sck;
  logic       mosi;
  logic       active;
  logic       done;
  logic [7:0] rx_byte;
  modport ctl (output start, tx_byte, cpol, cpha, spos, en, miso,
               input sck, mosi, active, done, rx_byte, edge_stb);
  modport eng (input start, tx_byte, cpol, cpha, spos, en, miso, edge_stb,
               output sck, mosi, active, done, rx_byte);
endinterface
`default_nettype wire

// *** smc_clkgen.sv ***
// Purpose: half-period strobe for the serial clock
// Assumes: divider may change only when not running
// Notes: strobe every divider+1 cycles while run is high
`timescale 1ns/1ns
`default_nettype none
module smc_clkgen import smc_pkg::*; (
  // System
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       run,
  input  wire logic [5:0] div,
  // Strobe
  output logic            edge_stb
);
  logic [5:0] cnt_q;

  // Compare with >= so a late divider change cannot run away
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q    <= 6'h00;
      edge_stb <= 1'b0;
    end else if (!run) begin
      cnt_q    <= 6'h00;
      edge_stb <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q    <= 6'h00;
      edge_stb <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 6'h01;
      edge_stb <= 1'b0;
    end
  end
endmodule // smc_clkgen
`default_nettype wire

// *** smc_shifter.sv ***
// Purpose: eight-bit shift engine with clock phase handling
// Assumes: start only while idle and enabled
// Notes: sixteen clock edges per byte
`timescale 1ns/1ns
`default_nettype none
module smc_shifter import smc_pkg::*; (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Link
  smc_link_if.eng  l
);
  smc_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic       smp_edge;
  logic       shf_edge;
  logic       cap_edge;
  logic       step;

  assign smp_edge  = l.cpha ? cnt_q[0] : ~cnt_q[0];
  assign shf_edge  = ~smp_edge;
  assign cap_edge  = l.spos ? shf_edge : smp_edge;
  assign step      = (state_q == SMC_SHIFT) && l.edge_stb;
  assign l.active  = (state_q == SMC_SHIFT);
  assign l.rx_byte = rx_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SMC_IDLE;
      cnt_q   <= 4'h0;
    end else if (!l.en) begin
      state_q <= SMC_IDLE;
    end else begin
      unique case (state_q)
        SMC_IDLE: if (l.start) begin
          state_q <= SMC_SHIFT;
          cnt_q   <= 4'h0;
        end
        SMC_SHIFT: if (l.edge_stb) begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == EDGE_LAST) state_q <= SMC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) l.sck <= SCK_RST;
    else if (state_q == SMC_IDLE) l.sck <= l.cpol;
    else if (l.edge_stb) l.sck <= ~l.sck;
  end

  // Phase 0 puts the MSB out before the first edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_q   <= 8'h00;
      l.mosi <= 1'b0;
    end else if (state_q == SMC_IDLE && l.start) begin
      sh_q <= l.cpha ? l.tx_byte : {l.tx_byte[6:0], 1'b0};
      if (!l.cpha) l.mosi <= l.tx_byte[7];
    end else if (step && shf_edge) begin
      l.mosi <= sh_q[7];
      sh_q   <= {sh_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) rx_q <= 8'h00;
    else if (step && cap_edge) rx_q <= {rx_q[6:0], l.miso};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) l.done <= 1'b0;
    else l.done <= step && (cnt_q == EDGE_LAST) && l.en;
  end
endmodule // smc_shifter
`default_nettype wire

// *** smc_top.sv ***
// Purpose: SPI master with clock setup and status flags
// Assumes: one-cycle strobes, read data one cycle later
// Notes: config bits 3:0 double as interrupt mask
`timescale 1ns/1ns
`default_nettype none
module smc_top import smc_pkg::*; (
  // System
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Serial link
  output logic             sclk,
  output logic             mosi,
  input  wire logic        miso,
  output logic             slave_select_n,
  // Interrupt
  output logic             irq
);
  smc_link_if lnk ();

  logic [7:0] cfg_q;
  logic [7:0] clk_q;
  logic [7:0] tx_q;
  logic       tx_full_q;
  logic [7:0] rx_q;
  logic       rx_full_q;
  logic       ovf_q;
  logic       txe_q;
  logic       wcol_q;
  logic       busy_q;
  logic       start_q;
  logic [7:0] launch_byte_q;
  logic       launch;
  logic       wr_cfg;
  logic       wr_data;
  logic       wr_clk;
  logic       wr_stat;
  logic       rd_data;
  logic       rd_stat;
  logic       flush;
  logic       rx_full_eff;
  logic [3:0] flags;
  logic [31:0] rd_val;

  // Address decode
  assign wr_cfg  = reg_wr && (reg_addr == CFG_ADDR);
  assign wr_data = reg_wr && (reg_addr == DATA_ADDR);
  assign wr_clk  = reg_wr && (reg_addr == CLK_ADDR);
  assign wr_stat = reg_wr && (reg_addr == STAT_ADDR);
  assign rd_data = reg_rd && (reg_addr == DATA_ADDR);
  assign rd_stat = reg_rd && (reg_addr == STAT_ADDR);
  assign flush   = wr_stat && reg_wdata[ST_FLUSH];

  // Link wiring
  assign lnk.start   = start_q;
  assign lnk.tx_byte = launch_byte_q;
  assign lnk.cpol    = clk_q[CLK_CPOL];
  assign lnk.cpha    = clk_q[CLK_CPHA];
  assign lnk.spos    = cfg_q[CFG_SPOS];
  assign lnk.en      = cfg_q[CFG_EN];
  assign lnk.miso    = miso;
  assign sclk        = lnk.sck;
  assign mosi        = lnk.mosi;

  smc_clkgen u_clkgen (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (lnk.active),
    .div      (clk_q[7:CLK_DIVLO]),
    .edge_stb (lnk.edge_stb)
  );

  smc_shifter u_shifter (
    .clk   (clk),
    .rst_n (rst_n),
    .l     (lnk)
  );

  // Configuration: mask, sample edge, select, enable
  always_ff @(posedge clk) begin
    if (!rst_n) cfg_q <= CFG_RST;
    else if (wr_cfg) cfg_q <= reg_wdata[7:0] & CFG_WMSK;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) slave_select_n <= CFG_RST[CFG_SEL];
    else if (wr_cfg) slave_select_n <= reg_wdata[CFG_SEL];
  end

  // Clock setup: polarity, phase, divider
  always_ff @(posedge clk) begin
    if (!rst_n) clk_q <= CLK_RST;
    else if (wr_clk) clk_q <= reg_wdata[7:0];
  end

  // Hand the buffered byte to the shifter when idle
  assign launch = cfg_q[CFG_EN] && tx_full_q && !lnk.active
                  && !start_q && !flush;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_q       <= 1'b0;
      launch_byte_q <= 8'h00;
    end else begin
      start_q <= launch;
      if (launch) launch_byte_q <= tx_q;
    end
  end

  // Transmit buffer; a write while full is rejected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_q      <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (flush || launch) begin
      tx_full_q <= 1'b0;
    end else if (wr_data && !tx_full_q) begin
      tx_q      <= reg_wdata[7:0];
      tx_full_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) txe_q <= ST_TXE_RST;
    else if (launch || flush) txe_q <= 1'b1;
    else if (wr_data) txe_q <= 1'b0;
  end

  // Set wins over the read that clears
  always_ff @(posedge clk) begin
    if (!rst_n) wcol_q <= 1'b0;
    else if (wr_data && tx_full_q) wcol_q <= 1'b1;
    else if (rd_stat || (wr_stat && reg_wdata[ST_WCOL])) wcol_q <= 1'b0;
  end

  // A data read in the same cycle frees the buffer first
  assign rx_full_eff = rx_full_q && !rd_data;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_q      <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (lnk.done && !rx_full_eff) begin
      rx_q      <= lnk.rx_byte;
      rx_full_q <= 1'b1;
    end else if (rd_data) begin
      rx_full_q <= 1'b0;
    end
  end

  // Overflow keeps the older byte
  always_ff @(posedge clk) begin
    if (!rst_n) ovf_q <= 1'b0;
    else if (lnk.done && rx_full_eff) ovf_q <= 1'b1;
    else if (rd_stat || (wr_stat && reg_wdata[ST_OVF])) ovf_q <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) busy_q <= 1'b0;
    else busy_q <= launch || start_q || lnk.active;
  end

  // Interrupt from enabled flags
  assign flags = {wcol_q, txe_q, rx_full_q, ovf_q};

  always_ff @(posedge clk) begin
    if (!rst_n) irq <= 1'b0;
    else irq <= |(flags & cfg_q[3:0]);
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (reg_addr)
      CFG_ADDR:  rd_val[7:0] = cfg_q;
      DATA_ADDR: rd_val[7:0] = rx_q;
      CLK_ADDR:  rd_val[7:0] = clk_q;
      STAT_ADDR: begin
        rd_val[ST_OVF]  = ovf_q;
        rd_val[ST_RXF]  = rx_full_q;
        rd_val[ST_TXE]  = txe_q;
        rd_val[ST_WCOL] = wcol_q;
        rd_val[ST_BUSY] = busy_q;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) reg_rdata <= rd_val;
    else reg_rdata <= 32'h0000_0000;
  end
endmodule // smc_top
`default_nettype wire

// *** smc_slave_model.sv ***
// Purpose: behavioural serial slave for the bench
// Assumes: one byte per select
// Notes: mode bits come from the bench
`timescale 1ns/1ns
`default_nettype none
module smc_slave_model (
  // Serial
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  output logic            miso,
  // Mode and data
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic      [3:0] bits
);
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    bits = 4'h0;
  end
  always @(negedge ss_n) begin
    sh = tx_byte;
    miso = tx_byte[7];
    bits = 4'h0;
  end
  // Released line flips so stale data never looks valid
  always @(posedge ss_n) miso = ~miso;
  always @(sclk) begin
    if (!ss_n && ((sclk != cpol) != cpha)) begin
      rx_byte = {rx_byte[6:0], mosi};
      bits = bits + 4'h1;
    end else if (!ss_n && cpha) begin
      miso = sh[7];
      sh = sh << 1;
    end else if (!ss_n) begin
      sh = sh << 1;
      miso = sh[7];
    end
  end
endmodule // smc_slave_model
`default_nettype wire

// *** smc_assertions.sv ***
// Purpose: port checks for smc_top
// Assumes: shadows follow register writes
// Notes: bound below
`timescale 1ns/1ns
`default_nettype none
module smc_assertions import smc_pkg::*; (
  // System
  input wire logic        clk,
  input wire logic        rst_n,
  // Registers
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Link
  input wire logic        sclk,
  input wire logic        mosi,
  input wire logic        miso,
  input wire logic        slave_select_n,
  input wire logic        irq
);
  logic       en_q, cpol_q, sclk_q;
  logic [5:0] div_q;
  logic [3:0] msk_q;
  logic [1:0] off_q;
  logic [7:0] gap_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q  <= 1'b0;
      msk_q <= 4'h0;
    end else if (reg_wr && reg_addr == CFG_ADDR) begin
      en_q  <= reg_wdata[CFG_EN];
      msk_q <= reg_wdata[3:0];
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpol_q <= 1'b1;
      div_q  <= 6'h01;
    end else if (reg_wr && reg_addr == CLK_ADDR) begin
      cpol_q <= reg_wdata[CLK_CPOL];
      div_q  <= reg_wdata[7:2];
    end
  end
  // Saturating so long idles never wrap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      off_q  <= 2'h0;
      gap_q  <= 8'hFF;
      sclk_q <= 1'b1;
    end else begin
      off_q  <= en_q ? 2'h0 : (off_q == 2'h3 ? off_q : off_q + 2'h1);
      gap_q  <= (sclk != sclk_q) ? 8'h01 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
      sclk_q <= sclk;
    end
  end
  sequence dwr; reg_wr && reg_addr == DATA_ADDR && !en_q; endsequence
  sequence srd; reg_rd && reg_addr == STAT_ADDR; endsequence
  sequence gap1; !(reg_wr || reg_rd); endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
  ssel_follow_a: assert property (reg_wr && reg_addr == CFG_ADDR ##1 !reg_wr
    |=> slave_select_n == $past(reg_wdata[CFG_SEL], 2)) else $error("select wrong");
  idle_level_a: assert property (off_q == 2'h3 && cpol_q == $past(cpol_q)
    |-> sclk == cpol_q) else $error("idle level wrong");
  clk_period_a: assert property (sclk != sclk_q && en_q
    |-> gap_q >= {2'h0, div_q} + 8'h01) else $error("sclk too fast");
  irq_mask_a: assert property (irq |-> (msk_q | $past(msk_q)) != 4'h0) else $error("irq unmasked");
  txe_clear_a: assert property (dwr ##1 gap1 ##1 srd |=> !reg_rdata[ST_TXE]) else $error("txe set");
  wcol_set_a: assert property (dwr ##1 gap1 ##1 dwr ##1 gap1 ##1 srd |=> reg_rdata[ST_WCOL])
    else $error("wcol missing");
  wcol_clear_a: assert property (srd ##0 !en_q ##1 gap1 ##1 srd |=> !reg_rdata[ST_WCOL])
    else $error("wcol stuck");
  irq_seen_c: cover property (irq);
  wcol_seen_c: cover property (srd ##1 reg_rdata[ST_WCOL]);
  edge_seen_c: cover property (sclk != sclk_q && en_q);
endmodule // smc_assertions
bind smc_top smc_assertions chk_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk), .mosi(mosi), .miso(miso),
  .slave_select_n(slave_select_n), .irq(irq));
`default_nettype wire

// *** tb_spi_master_clock_and_status.sv ***
// Purpose: self-checking bench for smc_top
// Assumes: slave model on the serial side
// Notes: one idle cycle between bus accesses
`timescale 1ns/1ns
`default_nettype none
module tb_spi_master_clock_and_status import smc_pkg::*;;
  logic        clk, rst_n, reg_wr, reg_rd, sclk, mosi, miso, ssel_n, irq, m_cpol, m_cpha, last_s;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, rdat;
  logic [7:0]  s_tx, s_rx, cnt_s, last_gap, tx;
  logic [3:0]  bits;
  logic [2:0]  mb;
  int          err_total, comparisons;
  smc_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk(sclk), .mosi(mosi), .miso(miso),
    .slave_select_n(ssel_n), .irq(irq));
  smc_slave_model slv (.sclk(sclk), .mosi(mosi), .ss_n(ssel_n), .miso(miso), .cpol(m_cpol),
    .cpha(m_cpha), .tx_byte(s_tx), .rx_byte(s_rx), .bits(bits));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    last_s <= sclk;
    if (sclk !== last_s) begin
      last_gap <= cnt_s;
      cnt_s <= 8'h01;
    end else cnt_s <= cnt_s + 8'h01;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rdat = reg_rdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, 1'b1, a, 32'h0);
    chk(nm, rdat, e);
  endtask
  task automatic xfer(input logic [7:0] b, input logic [31:0] st);
    int k;
    wr(DATA_ADDR, {24'h0, b});
    // Busy and transmit-empty must show while the byte is on the wire
    rdc(STAT_ADDR, st, "stat busy");
    for (k = 0; k < 400 && bits != 4'h8; k++) @(posedge clk);
    chk("xfer end", {31'h0, k < 400}, 32'h1);
    repeat (12) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, m_cpol, m_cpha} = 5'h00;
    {reg_addr, reg_wdata, s_tx} = 72'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(CFG_ADDR, 32'h40, "cfg reset");
    rdc(CLK_ADDR, 32'h07, "clk reset");
    rdc(STAT_ADDR, 32'h04, "stat reset");
    rdc(32'h4000_1830, 32'h0, "unmapped");
    wr(CLK_ADDR, 32'hFFFF_FFFF);
    rdc(CLK_ADDR, 32'hFF, "clk bits");
    wr(CFG_ADDR, 32'hFFFF_FF7F);
    rdc(CFG_ADDR, 32'h6F, "cfg bits");
    $display("register test done");
    for (int m = 0; m < 5; m++) begin
      mb = 3'(m);
      {m_cpha, m_cpol} = mb[1:0];
      tx = 8'h5A ^ {5'h0, mb};
      s_tx = 8'hC3 ^ {mb, 5'h0};
      wr(CFG_ADDR, 32'h40);
      wr(CLK_ADDR, {24'h0, 6'(mb[1:0]) + 6'h1, mb[1], mb[0]});
      repeat (3) @(posedge clk);
      chk("idle level", {31'h0, sclk}, {31'h0, mb[0]});
      wr(CFG_ADDR, {24'h0, 2'b10, mb[2], 3'h0, mb[0], 1'b0});
      xfer(tx, 32'h14);
      chk("slave rx", {24'h0, s_rx}, {24'h0, tx});
      chk("sclk gap", {24'h0, last_gap}, {30'h0, mb[1:0]} + 32'h2);
      chk("irq on", {31'h0, irq}, {31'h0, mb[0]});
      rdc(STAT_ADDR, 32'h06, "stat full");
      rdc(DATA_ADDR, {24'h0, s_tx}, "rx data");
      repeat (2) @(posedge clk);
      chk("irq off", {31'h0, irq}, 32'h0);
      rdc(STAT_ADDR, 32'h04, "stat empty");
      $display("mode %0d test done", m);
    end
    for (int i = 0; i < 2; i++) begin
      s_tx = (i == 0) ? 8'h3C : 8'h99;
      wr(CFG_ADDR, 32'hC0);
      wr(CFG_ADDR, 32'h80);
      xfer(8'h11, (i == 0) ? 32'h14 : 32'h16);
    end
    rdc(STAT_ADDR, 32'h07, "overflow");
    rdc(STAT_ADDR, 32'h06, "ovf cleared");
    rdc(DATA_ADDR, 32'h3C, "first kept");
    $display("overflow test done");
    wr(CFG_ADDR, 32'h40);
    wr(DATA_ADDR, 32'h01);
    wr(DATA_ADDR, 32'h02);
    rdc(STAT_ADDR, 32'h08, "collision");
    rdc(STAT_ADDR, 32'h00, "coll cleared");
    wr(CFG_ADDR, 32'h48);
    wr(DATA_ADDR, 32'h03);
    repeat (2) @(posedge clk);
    chk("irq coll", {31'h0, irq}, 32'h1);
    rdc(STAT_ADDR, 32'h08, "coll again");
    repeat (2) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(STAT_ADDR, 32'h80);
    rdc(STAT_ADDR, 32'h04, "flushed");
    $display("collision test done");
    tally_and_finish;
  end
endmodule // tb_spi_master_clock_and_status
`default_nettype wire
